// ===== verilog/dsf_consts.svh
// Register indices, bit positions and packing figures of the formatter
`ifndef DSF_CONSTS_SVH
`define DSF_CONSTS_SVH
`define DSF_CTRL_IDX 8'h02
`define DSF_STAT_IDX 8'h03
`define DSF_CTRL_RST 8'h00
`define DSF_B_PASS 0
`define DSF_B_WIDE 1
`define DSF_B_DITH 2
`define DSF_B_DBL 5
`define DSF_B_LCDEN 6
`define DSF_PIX_PER_WORD 4
`define DSF_BITS_PER_WORD 12
`define DSF_SHIFT_BITS 8
`define DSF_MAP_FRM 1'b0
`define DSF_MAP_DITH 1'b1
`endif

// ===== verilog/dsf_pkg.sv
// Types shared by the dual-scan panel formatter
`default_nettype none
package dsf_pkg;
  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } dsf_pixel_t;

  typedef struct packed {
    logic line_sync;
    logic frame_sync;
    logic display_enable;
    logic power_enable_in;
    logic bias_enable_in;
  } dsf_tft_ctl_t;

  typedef struct packed {
    logic [17:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } dsf_bank_req_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_UPPER = 2'b01,
    RD_LOWER = 2'b11,
    RD_EMIT = 2'b10
  } dsf_rd_state_t;
endpackage
`default_nettype wire

// ===== verilog/dsf_sync.sv
// Two-flop synchroniser, one chain per bit
`default_nettype none
module dsf_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk) begin
    meta_r <= i_d;
    o_q <= meta_r;
  end
endmodule // dsf_sync
`default_nettype wire

// ===== verilog/dsf_map_ram.sv
// Mapping RAM: write on one clock, registered reads on another
`default_nettype none
module dsf_map_ram #(
  parameter int DW = 64,
  parameter int AW = 5,
  parameter int NRD = 3
) (
  input wire logic i_wclk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_rclk,
  input wire logic i_rce,
  input wire logic [NRD*AW-1:0] i_raddr,
  output logic [NRD*DW-1:0] o_rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge i_wclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  genvar k;
  generate
    for (k = 0; k < NRD; k++) begin : g_rd
      always_ff @(posedge i_rclk) begin
        if (i_rce) begin
          o_rdata[k*DW +: DW] <= mem[i_raddr[k*AW +: AW]];
        end
      end
    end
  endgenerate
endmodule // dsf_map_ram
`default_nettype wire

// ===== verilog/dsf_top.sv
// Dual-scan panel formatter: control, maps, frame buffer, panel output
//
// Notes on behaviour
// R1: Control bit 0 picks pass-through output
// R2: Control bit 1 picks 24-bit packing
// R3: Packing bit ignored while pass-through set
// R4: Control register resets to zero
// R5: Pass-through pixel data is registered
// R6: Unassigned panel bits are driven low
// R7: Narrow mode: eight colour bits per half
// R8: Narrow mode continues stream across clocks
// R9: Wide mode: four whole pixels per half
// R10: Pass-through upper bus bit mapping
// R11: Pass-through lower bus bit mapping
// R12: Pass-through copies sync and enables
// R13: Double refresh shows each frame twice
// R14: Modulation map: 32 patterns of 64
// R15: Dither map: 16 patterns of 4x4
// R16: Pixels modulated, stored, read back
// R17: Two independent frame buffer banks
// R18: Shift clock marks each panel word
// R19: Frame marker pulses at frame start
// R20: Panel disable output is active low
// R21: Pass-through adds one cycle everywhere
`default_nettype none
`include "dsf_consts.svh"
module dsf_top #(
  parameter int H_PIXELS = 640,
  parameter int V_LINES = 480
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_map_wr,
  input wire logic i_map_sel,
  input wire logic [4:0] i_map_addr,
  input wire logic [63:0] i_map_wdata,
  input wire logic i_pixel_clock,
  input wire dsf_pkg::dsf_pixel_t i_pix,
  input wire dsf_pkg::dsf_tft_ctl_t i_tft,
  output dsf_pkg::dsf_bank_req_t [1:0] o_bank_req,
  input wire logic [1:0][15:0] i_bank_rdata,
  input wire logic [1:0] i_bank_rvalid,
  output logic [11:0] o_upper_half_bus,
  output logic [11:0] o_lower_half_bus,
  output logic o_panel_shift_clock,
  output logic o_frame_start_marker,
  output logic o_line_latch_pulse,
  output logic o_panel_disable_n,
  output logic o_panel_power_enable,
  output logic o_contrast_bias_enable
);
  localparam int LINE_WORDS = H_PIXELS / `DSF_PIX_PER_WORD;
  localparam int HALF_LINES = V_LINES / 2;
  localparam logic [17:0] HALF_OFS = 18'(HALF_LINES * LINE_WORDS);
  localparam logic [17:0] HALF_LAST = HALF_OFS - 18'h1;
  localparam logic [9:0] LW_LAST = 10'(LINE_WORDS - 1);
  localparam logic [4:0] WORD_BITS = 5'(`DSF_BITS_PER_WORD);
  localparam logic [4:0] SHIFT_BITS = 5'(`DSF_SHIFT_BITS);

  // ---------------- Register side (i_clk) ----------------
  logic [7:0] ctrl_r;
  logic [2:0] stat_s;
  logic frm_we;
  logic dit_we;

  // R4: cleared by reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= `DSF_CTRL_RST;
    end else if (i_ce && i_reg_wr && i_reg_addr == `DSF_CTRL_IDX) begin
      ctrl_r <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_ce) begin
      case (i_reg_addr)
        `DSF_CTRL_IDX: o_reg_rdata <= ctrl_r;
        `DSF_STAT_IDX: o_reg_rdata <= {5'h00, stat_s};
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  assign frm_we = i_ce && i_map_wr && i_map_sel == `DSF_MAP_FRM;
  assign dit_we = i_ce && i_map_wr && i_map_sel == `DSF_MAP_DITH;

  // ---------------- Crossings ----------------
  logic [9:0] px_s;
  logic px_rst_n;
  logic px_ce;
  logic [7:0] px_ctrl;
  logic [7:0] ctrl_q_r;
  logic [7:0] ctrl_s_r;
  logic pass;
  logic wide;
  logic pass2_r;
  logic rd_bank_r;
  logic wr_bank_r;

  // Quasi-static control levels into the pixel domain
  dsf_sync #(.W(10)) u_to_px (
    .i_clk(i_pixel_clock),
    .i_d({i_rst_n, i_ce, ctrl_r}),
    .o_q(px_s)
  );
  assign {px_rst_n, px_ce} = px_s[9:8];
  assign px_ctrl = ctrl_s_r;

  // Control word taken only after two equal samples
  always_ff @(posedge i_pixel_clock) begin
    ctrl_q_r <= px_s[7:0];
    if (ctrl_q_r == px_s[7:0]) begin
      ctrl_s_r <= ctrl_q_r;
    end
  end

  dsf_sync #(.W(3)) u_to_sys (
    .i_clk(i_clk),
    .i_d({pass2_r, rd_bank_r, wr_bank_r}),
    .o_q(stat_s)
  );

  // R1: mode select
  assign pass = px_ctrl[`DSF_B_PASS];
  // R3: width only counts without pass-through
  // R2: wide packing select
  assign wide = px_ctrl[`DSF_B_WIDE] & ~pass;

  // ---------------- Mapping RAMs ----------------
  logic [191:0] frm_q;
  logic [47:0] dit_q;

  // R14: modulation patterns
  dsf_map_ram #(.DW(64), .AW(5), .NRD(3)) u_frm_ram (
    .i_wclk(i_clk),
    .i_we(frm_we),
    .i_waddr(i_map_addr),
    .i_wdata(i_map_wdata),
    .i_rclk(i_pixel_clock),
    .i_rce(px_ce),
    .i_raddr({i_pix.red[5:1], i_pix.green[5:1], i_pix.blue[5:1]}),
    .o_rdata(frm_q)
  );

  // R15: dither patterns
  dsf_map_ram #(.DW(16), .AW(4), .NRD(3)) u_dit_ram (
    .i_wclk(i_clk),
    .i_we(dit_we),
    .i_waddr(i_map_addr[3:0]),
    .i_wdata(i_map_wdata[15:0]),
    .i_rclk(i_pixel_clock),
    .i_rce(px_ce),
    .i_raddr({i_pix.red[5:2], i_pix.green[5:2], i_pix.blue[5:2]}),
    .o_rdata(dit_q)
  );

  // ---------------- Input frame tracking ----------------
  logic vs_d_r;
  logic de_d_r;
  logic next_bank_r;
  logic [5:0] frm_frame_r;
  logic [1:0] y_r;
  logic [21:0] frame_cnt_r;
  logic [21:0] frame_len_r;
  logic start_pend_r;
  logic frame_start;
  logic mid_go;
  logic rd_take;

  assign frame_start = i_tft.frame_sync & ~vs_d_r;
  // R13: second pass halfway through the input frame
  assign mid_go = px_ctrl[`DSF_B_DBL] && !pass2_r && frame_len_r != '0
                  && frame_cnt_r == {1'b0, frame_len_r[21:1]};

  always_ff @(posedge i_pixel_clock) begin
    if (!px_rst_n) begin
      vs_d_r <= 1'b0;
      de_d_r <= 1'b0;
      wr_bank_r <= 1'b0;
      next_bank_r <= 1'b0;
      frm_frame_r <= 6'h00;
      y_r <= 2'h0;
      frame_cnt_r <= 22'h000000;
      frame_len_r <= 22'h000000;
      pass2_r <= 1'b0;
      start_pend_r <= 1'b0;
    end else if (px_ce) begin
      vs_d_r <= i_tft.frame_sync;
      de_d_r <= i_tft.display_enable;
      if (frame_start) begin
        // R17: swap banks, finished one goes to readout
        wr_bank_r <= ~wr_bank_r;
        next_bank_r <= wr_bank_r;
        frm_frame_r <= frm_frame_r + 6'h01;
        y_r <= 2'h0;
        frame_cnt_r <= 22'h000001;
        frame_len_r <= frame_cnt_r;
        pass2_r <= 1'b0;
      end else begin
        frame_cnt_r <= frame_cnt_r + 22'h000001;
        if (de_d_r && !i_tft.display_enable) begin
          y_r <= y_r + 2'h1;
        end
        if (mid_go) begin
          pass2_r <= 1'b1;
        end
      end
      if (frame_start || mid_go) begin
        start_pend_r <= 1'b1;
      end else if (rd_take) begin
        start_pend_r <= 1'b0;
      end
    end
  end

  // ---------------- Modulate, pack and store ----------------
  logic de1_r;
  logic [3:0] sel_r;
  logic [1:0] x_r;
  logic [8:0] pk_r;
  logic [1:0] pk_n_r;
  logic [17:0] wr_ptr_r;
  logic [2:0] pix3;
  logic wr_go;

  function automatic logic pick(input logic [63:0] frame_rate_modulation,
                                input logic [15:0] dit,
                                input logic dith,
                                input logic [5:0] fi,
                                input logic [3:0] di);
    pick = dith ? dit[di] : frame_rate_modulation[fi];
  endfunction

  // R16: one bit per colour after modulation or dither
  assign pix3 = {
    pick(frm_q[128 +: 64], dit_q[32 +: 16], px_ctrl[`DSF_B_DITH],
         frm_frame_r, sel_r),
    pick(frm_q[64 +: 64], dit_q[16 +: 16], px_ctrl[`DSF_B_DITH],
         frm_frame_r, sel_r),
    pick(frm_q[0 +: 64], dit_q[0 +: 16], px_ctrl[`DSF_B_DITH],
         frm_frame_r, sel_r)
  };
  assign wr_go = de1_r && pk_n_r == 2'h3;

  always_ff @(posedge i_pixel_clock) begin
    if (!px_rst_n) begin
      de1_r <= 1'b0;
      sel_r <= 4'h0;
      x_r <= 2'h0;
      pk_r <= 9'h000;
      pk_n_r <= 2'h0;
      wr_ptr_r <= 18'h00000;
    end else if (px_ce) begin
      de1_r <= i_tft.display_enable;
      sel_r <= {y_r, x_r};
      x_r <= i_tft.display_enable ? x_r + 2'h1 : 2'h0;
      if (frame_start) begin
        wr_ptr_r <= 18'h00000;
      end else if (wr_go) begin
        wr_ptr_r <= wr_ptr_r + 18'h00001;
      end
      if (!de1_r) begin
        pk_n_r <= 2'h0;
      end else begin
        pk_r <= {pk_r[5:0], pix3};
        pk_n_r <= pk_n_r + 2'h1;
      end
    end
  end

  // ---------------- Panel readout ----------------
  dsf_pkg::dsf_rd_state_t rd_st_r;
  logic [17:0] rd_ptr_r;
  logic [9:0] lw_r;
  logic rq_out_r;
  logic [11:0] up_w_r;
  logic [11:0] lo_w_r;
  logic [23:0] ubuf_r;
  logic [23:0] lbuf_r;
  logic [4:0] cnt_r;
  logic rvalid_b;
  logic [11:0] rdata_b;
  logic re_now;
  logic emit;
  logic emit_done;
  logic line_end;
  logic frame_end;
  logic load;

  assign rd_take = rd_st_r == dsf_pkg::RD_IDLE && start_pend_r && !pass;
  assign rvalid_b = i_bank_rvalid[rd_bank_r];
  assign rdata_b = i_bank_rdata[rd_bank_r][11:0];
  assign re_now = (rd_st_r == dsf_pkg::RD_UPPER
                   || rd_st_r == dsf_pkg::RD_LOWER) && !rq_out_r;
  assign load = rd_st_r == dsf_pkg::RD_LOWER && rq_out_r && rvalid_b;
  assign emit = rd_st_r == dsf_pkg::RD_EMIT && !o_panel_shift_clock;
  assign emit_done = wide || cnt_r < (SHIFT_BITS << 1);
  assign line_end = emit && emit_done && lw_r == LW_LAST;
  assign frame_end = line_end && rd_ptr_r == HALF_LAST;

  always_ff @(posedge i_pixel_clock) begin
    if (!px_rst_n) begin
      rd_st_r <= dsf_pkg::RD_IDLE;
      rd_bank_r <= 1'b0;
      rd_ptr_r <= 18'h00000;
      lw_r <= 10'h000;
      rq_out_r <= 1'b0;
      up_w_r <= 12'h000;
      lo_w_r <= 12'h000;
    end else if (px_ce) begin
      if (re_now) begin
        rq_out_r <= 1'b1;
      end else if (rvalid_b) begin
        rq_out_r <= 1'b0;
      end
      case (rd_st_r)
        dsf_pkg::RD_IDLE: begin
          if (rd_take) begin
            rd_bank_r <= next_bank_r;
            rd_ptr_r <= 18'h00000;
            lw_r <= 10'h000;
            rd_st_r <= dsf_pkg::RD_UPPER;
          end
        end
        dsf_pkg::RD_UPPER: begin
          if (rq_out_r && rvalid_b) begin
            up_w_r <= rdata_b;
            rd_st_r <= dsf_pkg::RD_LOWER;
          end
        end
        dsf_pkg::RD_LOWER: begin
          if (load) begin
            lo_w_r <= rdata_b;
            rd_st_r <= dsf_pkg::RD_EMIT;
          end
        end
        dsf_pkg::RD_EMIT: begin
          if (emit && emit_done) begin
            rd_ptr_r <= rd_ptr_r + 18'h00001;
            lw_r <= (lw_r == LW_LAST) ? 10'h000 : lw_r + 10'h001;
            rd_st_r <= frame_end ? dsf_pkg::RD_IDLE : dsf_pkg::RD_UPPER;
          end
        end
        default: rd_st_r <= dsf_pkg::RD_IDLE;
      endcase
    end
  end

  // R8: bit stream carries leftover colour bits forward
  always_ff @(posedge i_pixel_clock) begin
    if (!px_rst_n) begin
      ubuf_r <= 24'h000000;
      lbuf_r <= 24'h000000;
      cnt_r <= 5'h00;
    end else if (px_ce) begin
      if (load) begin
        ubuf_r <= ubuf_r | ({up_w_r, 12'h000} >> cnt_r);
        lbuf_r <= lbuf_r | ({rdata_b, 12'h000} >> cnt_r);
        cnt_r <= cnt_r + WORD_BITS;
      end else if (emit && (wide || line_end)) begin
        ubuf_r <= 24'h000000;
        lbuf_r <= 24'h000000;
        cnt_r <= 5'h00;
      end else if (emit) begin
        ubuf_r <= ubuf_r << SHIFT_BITS;
        lbuf_r <= lbuf_r << SHIFT_BITS;
        cnt_r <= cnt_r - SHIFT_BITS;
      end
    end
  end

  // R17: each bank driven on its own, write and read never share one
  always_ff @(posedge i_pixel_clock) begin
    if (!px_rst_n) begin
      o_bank_req <= '0;
    end else if (px_ce) begin
      for (int b = 0; b < 2; b++) begin
        o_bank_req[b].we <= wr_go && wr_bank_r == 1'(b);
        o_bank_req[b].re <= re_now && rd_bank_r == 1'(b);
        o_bank_req[b].wdata <= {4'h0, pk_r, pix3};
        if (wr_bank_r == 1'(b)) begin
          o_bank_req[b].addr <= wr_ptr_r;
        end else if (rd_st_r == dsf_pkg::RD_LOWER) begin
          o_bank_req[b].addr <= rd_ptr_r + HALF_OFS;
        end else begin
          o_bank_req[b].addr <= rd_ptr_r;
        end
      end
    end
  end

  // ---------------- Panel outputs ----------------
  always_ff @(posedge i_pixel_clock) begin
    if (!px_rst_n) begin
      o_upper_half_bus <= 12'h000;
      o_lower_half_bus <= 12'h000;
      o_panel_shift_clock <= 1'b0;
      o_frame_start_marker <= 1'b0;
      o_line_latch_pulse <= 1'b0;
      o_panel_disable_n <= 1'b0;
      o_panel_power_enable <= 1'b0;
      o_contrast_bias_enable <= 1'b0;
    end else if (px_ce) begin
      if (pass) begin
        // R5: input captured in the output flops
        // R21: one cycle for data and controls alike
        // R10: upper bus mapping, R6: top nibble low
        o_upper_half_bus <= {4'h0, i_pix.red[0], i_pix.red[1],
                             i_pix.red[2], i_pix.green[0], i_pix.blue[2],
                             i_pix.red[3], i_pix.green[3], i_pix.blue[3]};
        // R11: lower bus mapping, R6: top bits low
        o_lower_half_bus <= {2'h0, i_pix.blue[5], i_pix.green[5],
                             i_pix.green[1], i_pix.green[2], i_pix.blue[0],
                             i_pix.blue[1], i_pix.red[4], i_pix.green[4],
                             i_pix.blue[4], i_pix.red[5]};
        // R12: sync and enables copied through
        o_line_latch_pulse <= i_tft.line_sync;
        o_frame_start_marker <= i_tft.frame_sync;
        o_panel_shift_clock <= ~o_panel_shift_clock;
        o_panel_disable_n <= i_tft.display_enable;
        o_panel_power_enable <= i_tft.power_enable_in;
        o_contrast_bias_enable <= i_tft.bias_enable_in;
      end else begin
        if (emit && wide) begin
          // R9: four pixels per half, pixel 0 on top
          o_upper_half_bus <= up_w_r;
          o_lower_half_bus <= lo_w_r;
        end else if (emit) begin
          // R7: eight bits per half, R6: top nibble low
          o_upper_half_bus <= {4'h0, ubuf_r[23:16]};
          o_lower_half_bus <= {4'h0, lbuf_r[23:16]};
        end
        // R18: one high cycle per presented word
        o_panel_shift_clock <= emit;
        o_line_latch_pulse <= line_end;
        // R19: pulse as a panel frame begins
        o_frame_start_marker <= rd_take;
        // R20: low keeps the panel disabled
        o_panel_disable_n <= px_ctrl[`DSF_B_LCDEN];
        o_panel_power_enable <= px_ctrl[`DSF_B_LCDEN];
        o_contrast_bias_enable <= px_ctrl[`DSF_B_LCDEN];
      end
    end
  end
endmodule // dsf_top
`default_nettype wire

// ===== testbench/dsf_bank_model.sv
// Behavioural frame buffer bank for the formatter's far side
`default_nettype none
module dsf_bank_model #(
  parameter int LAT = 1
) (
  input wire logic i_clk,
  input wire dsf_pkg::dsf_bank_req_t i_req,
  output logic [15:0] o_rdata,
  output logic o_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [64];
  logic [15:0] last;
  logic [5:0] ra;
  int cnt;
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    last = 16'h0000;
    cnt = 0;
    o_rvalid = 1'b0;
    o_rdata = 16'hffff;
  end
  always @(posedge i_clk) begin
    o_rvalid <= 1'b0;
    o_rdata <= ~last;
    if (i_req.we) mem[i_req.addr[5:0]] <= i_req.wdata;
    if (i_req.re) begin
      cnt <= LAT;
      ra <= i_req.addr[5:0];
    end else if (cnt == 1) begin
      o_rvalid <= 1'b1;
      o_rdata <= mem[ra];
      last <= mem[ra];
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule // dsf_bank_model
`default_nettype wire

// ===== testbench/dsf_top_asserts.sv
// Port checker of the dual-scan panel formatter
`default_nettype none
module dsf_top_asserts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_pixel_clock,
  input wire dsf_pkg::dsf_pixel_t i_pix,
  input wire dsf_pkg::dsf_tft_ctl_t i_tft,
  input wire dsf_pkg::dsf_bank_req_t [1:0] o_bank_req,
  input wire logic [11:0] o_upper_half_bus,
  input wire logic [11:0] o_lower_half_bus,
  input wire logic o_panel_shift_clock,
  input wire logic o_frame_start_marker,
  input wire logic o_line_latch_pulse,
  input wire logic o_panel_disable_n,
  input wire logic o_panel_power_enable,
  input wire logic o_contrast_bias_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh_r;
  logic [3:0] md_r;
  logic [2:0] cnt_r;
  logic stb, pt, pv;
  // Shadow of the control byte
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sh_r <= 8'h00;
    end else if (i_reg_wr && i_reg_addr == 8'h02) begin
      sh_r <= i_reg_wdata;
    end
  end
  // Age of the mode in pixel clocks
  always_ff @(posedge i_pixel_clock) begin
    md_r <= {sh_r[6], sh_r[5], sh_r[1], sh_r[0]};
    if (!i_rst_n || md_r != {sh_r[6], sh_r[5], sh_r[1], sh_r[0]}) begin
      cnt_r <= 3'h0;
    end else if (cnt_r != 3'h7) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
  assign stb = cnt_r >= 3'h6;
  assign pt = stb && md_r[0];
  assign pv = stb && !md_r[0];
  function automatic logic [11:0] up_map(dsf_pkg::dsf_pixel_t p);
    return {4'h0, p.red[0], p.red[1], p.red[2], p.green[0], p.blue[2],
      p.red[3], p.green[3], p.blue[3]};
  endfunction
  function automatic logic [11:0] lo_map(dsf_pkg::dsf_pixel_t p);
    return {2'b00, p.blue[5], p.green[5], p.green[1], p.green[2], p.blue[0],
      p.blue[1], p.red[4], p.green[4], p.blue[4], p.red[5]};
  endfunction
  property p_pix(a, b);
    @(posedge i_pixel_clock) disable iff (!i_rst_n) a |-> b;
  endproperty
  property p_pulse(s);
    @(posedge i_pixel_clock) disable iff (!i_rst_n) s |=> !s;
  endproperty
  a_rdata_ctrl: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_reg_addr == 8'h02 |=> o_reg_rdata == $past(sh_r))
    else $error("control read back wrong");
  a_rdata_unmap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_reg_addr != 8'h02 && i_reg_addr != 8'h03 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_pass_upper: assert property (p_pix(pt,
    o_upper_half_bus == up_map($past(i_pix)))) else $error("upper pass bad");
  a_pass_lower: assert property (p_pix(pt,
    o_lower_half_bus == lo_map($past(i_pix)))) else $error("lower pass bad");
  a_pass_ctl: assert property (p_pix(pt, {o_line_latch_pulse,
    o_frame_start_marker, o_panel_disable_n, o_panel_power_enable,
    o_contrast_bias_enable} == $past(i_tft))) else $error("pass ctl bad");
  a_pass_shift: assert property (p_pix(pt,
    $changed(o_panel_shift_clock))) else $error("pass shift stuck");
  a_narrow_unused: assert property (p_pix(pv && !md_r[1] &&
    o_panel_shift_clock, (o_upper_half_bus[11:8] | o_lower_half_bus[11:8])
    == 4'h0)) else $error("narrow high bits set");
  a_shift_pulse: assert property (@(posedge i_pixel_clock)
    disable iff (!i_rst_n) pv && o_panel_shift_clock |=> !o_panel_shift_clock)
    else $error("shift pulse too long");
  a_panel_off: assert property (p_pix(pv && !md_r[3],
    !o_panel_disable_n)) else $error("panel not disabled");
  a_one_writer: assert property (p_pix(1'b1,
    !(o_bank_req[0].we && o_bank_req[1].we))) else $error("both banks written");
  a_re_pulse0: assert property (p_pulse(o_bank_req[0].re))
    else $error("bank 0 read too long");
  a_re_pulse1: assert property (p_pulse(o_bank_req[1].re))
    else $error("bank 1 read too long");
  c_pass: cover property (@(posedge i_pixel_clock) pt);
  c_wide: cover property (@(posedge i_pixel_clock)
    pv && md_r[1] && o_panel_shift_clock);
  c_dbl: cover property (@(posedge i_pixel_clock)
    pv && md_r[2] && o_panel_shift_clock);
endmodule // dsf_top_asserts
bind dsf_top dsf_top_asserts u_chk (.i_clk, .i_rst_n, .i_reg_wr, .i_reg_addr,
  .i_reg_wdata, .o_reg_rdata, .i_pixel_clock, .i_pix, .i_tft, .o_bank_req,
  .o_upper_half_bus, .o_lower_half_bus, .o_panel_shift_clock,
  .o_frame_start_marker, .o_line_latch_pulse, .o_panel_disable_n,
  .o_panel_power_enable, .o_contrast_bias_enable);
`default_nettype wire

// ===== testbench/tb_dual_scan_panel_formatter.sv
// Self-checking bench of the dual-scan panel formatter
`default_nettype none
module tb_dual_scan_panel_formatter;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int H = 8;
  localparam int V = 4;
  logic i_clk, i_rst_n, i_ce, i_reg_wr, i_map_wr, i_map_sel, i_pixel_clock;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, d;
  logic [4:0] i_map_addr;
  logic [63:0] i_map_wdata;
  dsf_pkg::dsf_pixel_t i_pix;
  dsf_pkg::dsf_tft_ctl_t i_tft;
  dsf_pkg::dsf_bank_req_t [1:0] o_bank_req;
  wire logic [1:0][15:0] i_bank_rdata;
  wire logic [1:0] i_bank_rvalid;
  logic [11:0] o_upper_half_bus, o_lower_half_bus;
  logic o_panel_shift_clock, o_frame_start_marker, o_line_latch_pulse;
  logic o_panel_disable_n, o_panel_power_enable, o_contrast_bias_enable;
  logic mon, mon_d;
  int num_errors, comparisons, cycles, seed, j, mon_w;
  dsf_pkg::dsf_pixel_t cur [32];
  dsf_pkg::dsf_pixel_t prev [32];
  dsf_top #(.H_PIXELS(H), .V_LINES(V)) dut (
    .i_clk, .i_rst_n, .i_ce, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .i_map_wr, .i_map_sel, .i_map_addr, .i_map_wdata,
    .i_pixel_clock, .i_pix, .i_tft, .o_bank_req, .i_bank_rdata,
    .i_bank_rvalid, .o_upper_half_bus, .o_lower_half_bus,
    .o_panel_shift_clock, .o_frame_start_marker, .o_line_latch_pulse,
    .o_panel_disable_n, .o_panel_power_enable, .o_contrast_bias_enable
  );
  // Fast and slow banks
  dsf_bank_model #(.LAT(1)) u_bank0 (.i_clk(i_pixel_clock),
    .i_req(o_bank_req[0]), .o_rdata(i_bank_rdata[0]),
    .o_rvalid(i_bank_rvalid[0]));
  dsf_bank_model #(.LAT(3)) u_bank1 (.i_clk(i_pixel_clock),
    .i_req(o_bank_req[1]), .o_rdata(i_bank_rdata[1]),
    .o_rvalid(i_bank_rvalid[1]));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  initial begin
    i_pixel_clock = 1'b0;
    #1.3;
    forever #3 i_pixel_clock = ~i_pixel_clock;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(logic [11:0] seen, logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(logic [7:0] a, logic [7:0] v);
    @(negedge i_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = v;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask
  task automatic reg_rd(logic [7:0] a, logic [7:0] e);
    @(negedge i_clk) i_reg_addr = a;
    repeat (2) @(negedge i_clk);
    chk({4'h0, o_reg_rdata}, {4'h0, e});
  endtask
  task automatic map_wr(logic s, logic [4:0] a, logic [63:0] v);
    @(negedge i_clk);
    i_map_wr = 1'b1;
    i_map_sel = s;
    i_map_addr = a;
    i_map_wdata = v;
    @(negedge i_clk);
    i_map_wr = 1'b0;
  endtask
  // Packed colour stream of one panel half of the previous frame
  function automatic logic [11:0] exp_bus(int k, int w, logic dt, int h);
    logic [47:0] s;
    dsf_pkg::dsf_pixel_t p;
    s = '0;
    for (int i = 0; i < 16; i++) begin
      p = prev[h * 16 + i];
      s = {s[44:0], dt ? {p.red[5], p.green[5], p.blue[5]}
        : {p.red[1], p.green[1], p.blue[1]}};
    end
    s = s << (w * k);
    return (w == 12) ? s[47:36] : {4'h0, s[47:40]};
  endfunction
  always @(negedge i_pixel_clock) begin
    if (mon && o_panel_shift_clock === 1'b1) begin
      chk(o_upper_half_bus, exp_bus(j % (48 / mon_w), mon_w, mon_d, 0));
      chk(o_lower_half_bus, exp_bus(j % (48 / mon_w), mon_w, mon_d, 1));
      j++;
    end
  end
  task automatic send_frame();
    @(negedge i_pixel_clock) i_tft.frame_sync = 1'b1;
    repeat (2) @(negedge i_pixel_clock);
    i_tft.frame_sync = 1'b0;
    repeat (4) @(negedge i_pixel_clock);
    for (int l = 0; l < V; l++) begin
      for (int p = 0; p < H; p++) begin
        i_pix = 18'($random(seed));
        cur[l * H + p] = i_pix;
        i_tft.display_enable = 1'b1;
        @(negedge i_pixel_clock);
      end
      i_tft.display_enable = 1'b0;
      i_tft.line_sync = 1'b1;
      @(negedge i_pixel_clock);
      i_tft.line_sync = 1'b0;
      repeat (60) @(negedge i_pixel_clock);
    end
  endtask
  task automatic run(logic [7:0] c, int w, logic dt, int m);
    reg_wr(8'h02, c);
    mon = 1'b0;
    send_frame();
    send_frame();
    prev = cur;
    j = 0;
    mon_w = w;
    mon_d = dt;
    mon = 1'b1;
    send_frame();
    repeat (80) @(negedge i_pixel_clock);
    mon = 1'b0;
    chk(12'(j), 12'(m * 48 / w));
  endtask
  initial begin
    seed = 51;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    j = 0;
    mon = 1'b0;
    mon_d = 1'b0;
    mon_w = 12;
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    i_map_wr = 1'b0;
    i_map_sel = 1'b0;
    i_map_addr = 5'h00;
    i_map_wdata = 64'h0;
    i_pix = '0;
    i_tft = '0;
    repeat (16) @(negedge i_clk);
    chk({4'h0, o_reg_rdata}, 12'h000);
    chk(o_upper_half_bus | o_lower_half_bus, 12'h000);
    chk(12'(o_panel_disable_n), 12'h000);
    i_rst_n = 1'b1;
    reg_rd(8'h02, 8'h00);
    for (int k = 0; k < 6; k++) begin
      d = 8'($random(seed));
      reg_wr(8'h02, d);
      reg_rd(8'h02, d);
      reg_wr(8'h03, ~d);
      reg_rd(8'h02, d);
      reg_rd({2'b01, d[5:0]}, 8'h00);
    end
    for (int k = 0; k < 32; k++) map_wr(1'b0, 5'(k), {64{k[0]}});
    for (int k = 0; k < 16; k++) map_wr(1'b1, 5'(k), {48'h0, {16{k[3]}}});
    run(8'h40, 8, 1'b0, 1);
    run(8'h42, 12, 1'b0, 1);
    run(8'h44, 8, 1'b1, 1);
    run(8'h62, 12, 1'b0, 2);
    for (int k = 1; k < 4; k += 2) begin
      reg_wr(8'h02, 8'(k));
      repeat (8) @(negedge i_pixel_clock);
      repeat (40) begin
        @(negedge i_pixel_clock);
        chk(12'(o_line_latch_pulse), 12'(i_tft.line_sync));
        chk(o_upper_half_bus & 12'hf00, 12'h000);
        i_pix = 18'($random(seed));
        i_tft = 5'($random(seed));
      end
    end
    test_done();
  end
endmodule // tb_dual_scan_panel_formatter
`default_nettype wire
